// ---- src/four_channel_power_sequencer.sv ----
/*
 four_channel_power_sequencer: digital core sequencing four supplies on and off.
 assumes: threshold comparators outside give clean levels; the shared fault
 line is open drain with an external pull-up, resolved by the surroundings.
*/
// Operation
// - on command high starts power-on
// - delay timer runs before first enable
// - each enable starts its power-good timeout
// - good input high enables hysteresis source
// - confirmed supply resets power-good timeout
// - delay then next channel, order 1-4
// - fourth confirmed drives complete output low
// - timeout drops all enables, fault low
// - power-off only after completed power-on
// - power-off disables channel four first
// - off wait, delay, no timeout used
// - power-off end releases complete output
// - timeout can be disabled entirely
// - minimum-delay setting for the timer
// - early on-command removal is a fault
// - supply dropping while on is fault
// - fault clears when command and goods low, fault line high
// - external fault drops enables at once
`default_nettype none
module four_channel_power_sequencer
   import pwr_seq_pkg::*;
#(
   parameter logic [COUNT_W-1:0] DELAY_COUNT = COUNT_W'(DELAY_CYCLES),
   parameter logic [COUNT_W-1:0] PGT_COUNT   = COUNT_W'(PGT_CYCLES)
) (
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        on_cmd,
   input  wire logic [3:0]  supply_good_in,
   input  wire logic        fault_n_in,
   input  wire logic        pgt_enable,
   input  wire logic        min_delay,
   output logic      [3:0]  supply_enable_out,
   output logic      [3:0]  hysteresis_enable,
   output logic             done_n_out,
   output logic             done_n_oe,
   output logic             fault_n_out,
   output logic             fault_n_oe,
   output logic             internal_fault
);
   // ****************************************
   // input synchronisation
   // ****************************************
   seq_inputs_s raw;
   seq_inputs_s in_s;
   logic [5:0]  sync_bus;

   // fault line is carried active high from here on
   assign raw = '{on_cmd:         on_cmd,
                  supply_good_in: supply_good_in,
                  fault_in:       ~fault_n_in};

   sync3 #(
      .WIDTH (6)
   ) u_sync (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .async_in (raw),
      .sync_out (sync_bus)
   );
   assign in_s = sync_bus;

   // ****************************************
   // state and channel pointer
   // ****************************************
   seq_state_e            state_reg;
   logic [1:0]            chan_reg;
   logic [COUNT_W-1:0]    delay_cnt_reg;
   logic [COUNT_W-1:0]    pgt_cnt_reg;
   logic                  pgt_run_reg;
   logic                  fault_own_reg;
   logic                  fault_ext_reg;
   logic [COUNT_W-1:0]    delay_limit;
   logic                  delay_expired;
   logic                  pgt_expired;
   logic                  clear_ok;
   logic                  ext_fault_seen;
   logic [3:0]            expected_on;
   logic                  drop_fault;

   function automatic logic [3:0] mask_below(input logic [1:0] ch);
      mask_below = (4'h1 << ch) - 4'h1;
   endfunction : mask_below

   // power-off states, where the complete line is still pulled low
   function automatic logic in_power_off(input seq_state_e st);
      in_power_off = (st == ST_OFF_WAIT) || (st == ST_OFF_DLY);
   endfunction : in_power_off

   // min delay setting shortens the timer to one cycle
   assign delay_limit   = min_delay ? COUNT_W'(MIN_DELAY_CYCLES) : DELAY_COUNT;
   assign delay_expired = (delay_cnt_reg >= delay_limit);
   assign pgt_expired   = pgt_enable && pgt_run_reg && (pgt_cnt_reg >= PGT_COUNT);
   assign clear_ok      = !in_s.on_cmd && (in_s.supply_good_in == 4'h0) && !in_s.fault_in;
   // our own pull-down keeps the line low, so only a low we did not cause counts
   assign ext_fault_seen = in_s.fault_in && !fault_own_reg && !fault_ext_reg;

   // supplies that ought to be up in the current state
   always_comb begin
      case (state_reg)
         ST_ON_DELAY: expected_on = mask_below(chan_reg);
         ST_ON_WAIT:  expected_on = mask_below(chan_reg);
         ST_DONE:     expected_on = 4'hF;
         ST_OFF_WAIT: expected_on = mask_below(chan_reg);
         ST_OFF_DLY:  expected_on = mask_below(chan_reg);
         default:     expected_on = 4'h0;
      endcase
   end

   // ****************************************
   // fault detection
   // ****************************************
   // a supply that ought to be up has sagged
   assign drop_fault = (state_reg != ST_FAULT) && (state_reg != ST_IDLE) &&
                       ((expected_on & ~in_s.supply_good_in) != 4'h0);

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state_reg     <= ST_IDLE;
         chan_reg      <= 2'h0;
         fault_own_reg <= 1'b0;
         fault_ext_reg <= 1'b0;
      end else if (state_reg != ST_FAULT && ext_fault_seen) begin
         state_reg     <= ST_FAULT;
         fault_ext_reg <= 1'b1;
      end else if (drop_fault) begin
         state_reg     <= ST_FAULT;
         fault_own_reg <= 1'b1;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               chan_reg <= 2'h0;
               if (in_s.on_cmd) begin
                  state_reg <= ST_ON_DELAY;
               end
            end
            ST_ON_DELAY: begin
               if (!in_s.on_cmd) begin
                  state_reg     <= ST_FAULT;
                  fault_own_reg <= 1'b1;
               end else if (delay_expired) begin
                  state_reg <= ST_ON_WAIT;
               end
            end
            ST_ON_WAIT: begin
               if (!in_s.on_cmd) begin
                  state_reg     <= ST_FAULT;
                  fault_own_reg <= 1'b1;
               end else if (pgt_expired) begin
                  state_reg     <= ST_FAULT;
                  fault_own_reg <= 1'b1;
               end else if (in_s.supply_good_in[chan_reg]) begin
                  if (chan_reg == 2'h3) begin
                     state_reg <= ST_DONE;
                  end else begin
                     chan_reg  <= chan_reg + 2'h1;
                     state_reg <= ST_ON_DELAY;
                  end
               end
            end
            ST_DONE: begin
               if (!in_s.on_cmd) begin
                  state_reg <= ST_OFF_WAIT;
               end
            end
            ST_OFF_WAIT: begin
               // command raised again before power-off ends is a controller error
               if (in_s.on_cmd) begin
                  state_reg     <= ST_FAULT;
                  fault_own_reg <= 1'b1;
               end else if (!in_s.supply_good_in[chan_reg]) begin
                  if (chan_reg == 2'h0) begin
                     state_reg <= ST_IDLE;
                  end else begin
                     state_reg <= ST_OFF_DLY;
                  end
               end
            end
            ST_OFF_DLY: begin
               if (in_s.on_cmd) begin
                  state_reg     <= ST_FAULT;
                  fault_own_reg <= 1'b1;
               end else if (delay_expired) begin
                  chan_reg  <= chan_reg - 2'h1;
                  state_reg <= ST_OFF_WAIT;
               end
            end
            ST_FAULT: begin
               // stays here until the command and every supply are low and the fault line is released
               if (clear_ok) begin
                  state_reg     <= ST_IDLE;
                  fault_own_reg <= 1'b0;
                  fault_ext_reg <= 1'b0;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // delay timer
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         delay_cnt_reg <= '0;
      end else if (state_reg == ST_ON_DELAY || state_reg == ST_OFF_DLY) begin
         if (!delay_expired) begin
            delay_cnt_reg <= delay_cnt_reg + COUNT_W'(1);
         end
      end else begin
         delay_cnt_reg <= '0;
      end
   end

   // ****************************************
   // power-good timeout, only in power-on wait
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         pgt_cnt_reg <= '0;
         pgt_run_reg <= 1'b0;
      end else if (state_reg == ST_ON_WAIT && !in_s.supply_good_in[chan_reg]) begin
         pgt_run_reg <= 1'b1;
         // saturates so a long stall cannot wrap below the limit
         if (pgt_cnt_reg != PGT_COUNT) begin
            pgt_cnt_reg <= pgt_cnt_reg + COUNT_W'(1);
         end
      end else begin
         pgt_cnt_reg <= '0;
         pgt_run_reg <= 1'b0;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         supply_enable_out <= ENABLES_RESET;
      // outside fault drops the enables in the same cycle the state turns
      end else if (state_reg == ST_FAULT || ext_fault_seen) begin
         supply_enable_out <= 4'h0;
      end else begin
         case (state_reg)
            ST_ON_DELAY: supply_enable_out <= mask_below(chan_reg);
            ST_ON_WAIT:  supply_enable_out <= mask_below(chan_reg) | (4'h1 << chan_reg);
            ST_DONE:     supply_enable_out <= 4'hF;
            ST_OFF_WAIT: supply_enable_out <= mask_below(chan_reg);
            ST_OFF_DLY:  supply_enable_out <= mask_below(chan_reg);
            default:     supply_enable_out <= 4'h0;
         endcase
      end
   end

   // source follows the good input once it has been seen high
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         hysteresis_enable <= 4'h0;
      end else begin
         hysteresis_enable <= in_s.supply_good_in;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         done_n_oe <= 1'b0;
      end else begin
         // held through power-off, released once the last supply is down
         done_n_oe <= (state_reg == ST_DONE) || in_power_off(state_reg);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         fault_n_oe     <= 1'b0;
         internal_fault <= 1'b0;
      end else begin
         fault_n_oe     <= (state_reg == ST_FAULT);
         internal_fault <= fault_own_reg;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         done_n_out  <= 1'b0;
         fault_n_out <= 1'b0;
      end else begin
         done_n_out  <= 1'b0;
         fault_n_out <= 1'b0;
      end
   end
endmodule : four_channel_power_sequencer
`default_nettype wire

// ---- src/pwr_seq_pkg.sv ----
/*
 pwr_seq_pkg: constants, states and carriers for the four-channel power sequencer.
 assumes: single 40 MHz ref_clk domain; thresholds arrive as digital levels.
*/
`default_nettype none
package pwr_seq_pkg;
   localparam int unsigned CHANNELS         = 4;
   localparam int unsigned CLK_FREQ_HZ      = 40_000_000;
   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned DELAY_TIME_US    = 1000;
   localparam int unsigned PGT_TIME_US      = 10000;
   localparam int unsigned DELAY_CYCLES     = (DELAY_TIME_US * (CLK_FREQ_HZ / 1_000_000));
   localparam int unsigned PGT_CYCLES       = (PGT_TIME_US * (CLK_FREQ_HZ / 1_000_000));
   localparam int unsigned MIN_DELAY_CYCLES = 1;
   localparam int unsigned COUNT_W          = 24;
   localparam logic [3:0]  ENABLES_RESET    = 4'h0;

   typedef enum logic [6:0] {
      ST_IDLE     = 7'b0000001,
      ST_ON_DELAY = 7'b0000010,
      ST_ON_WAIT  = 7'b0000100,
      ST_DONE     = 7'b0001000,
      ST_OFF_WAIT = 7'b0010000,
      ST_OFF_DLY  = 7'b0100000,
      ST_FAULT    = 7'b1000000
   } seq_state_e;

   typedef struct packed {
      logic       on_cmd;
      logic [3:0] supply_good_in;
      logic       fault_in;
   } seq_inputs_s;

   typedef struct packed {
      logic       pgt_enable;
      logic       min_delay;
      logic [23:0] delay_count;
      logic [23:0] pgt_count;
   } seq_config_s;
endpackage : pwr_seq_pkg
`default_nettype wire

// ---- src/sync3.sv ----
/*
 sync3: three-flop synchroniser for a bus of pin inputs; a new level is taken
 once the second and third flops agree.
 assumes: inputs asynchronous to clk.
*/
`default_nettype none
module sync3 #(
   parameter int unsigned WIDTH = 6
) (
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= async_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // per-bit agreement filter
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         sync_out <= '0;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               sync_out[i] <= s3_reg[i];
            end
         end
      end
   end
endmodule : sync3
`default_nettype wire

// ---- testbench/pwr_seq_asserts.sv ----
/* pwr_seq_asserts: port checks for the sequencer.
 assumes: bound to four_channel_power_sequencer. */
`default_nettype none
module pwr_seq_asserts
   import pwr_seq_pkg::*;
#(
   parameter logic [COUNT_W-1:0] DELAY_COUNT = 24'h000008,
   parameter logic [COUNT_W-1:0] PGT_COUNT   = 24'h000040
) (
   input wire logic       ref_clk,
   input wire logic       rstn,
   input wire logic       on_cmd,
   input wire logic       pgt_enable,
   input wire logic       min_delay,
   input wire logic       fault_n_in,
   input wire logic [3:0] supply_enable_out,
   input wire logic [3:0] hysteresis_enable,
   input wire logic       done_n_out,
   input wire logic       done_n_oe,
   input wire logic       fault_n_out,
   input wire logic       fault_n_oe,
   input wire logic       internal_fault
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // ****
   // helper counters
   // ****
   logic [COUNT_W-1:0] on_reg, stuck_reg;
   always_ff @(posedge ref_clk) begin
      on_reg <= (!rstn || !on_cmd) ? '0 : on_reg + 1'b1;
   end
   // cycles an enabled channel waits for good
   always_ff @(posedge ref_clk) begin
      if (!rstn || !pgt_enable || done_n_oe || (supply_enable_out & ~hysteresis_enable) == 4'h0) begin
         stuck_reg <= '0;
      end else begin
         stuck_reg <= stuck_reg + 1'b1;
      end
   end
   sequence ext_pull;
      !fault_n_in [*8];
   endsequence
   sequence rise_done;
      $rose(done_n_oe);
   endsequence
   AST_ORDER: assert property (supply_enable_out inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
      else $error("enables out of order");
   AST_FIRST_DELAY: assert property ($rose(supply_enable_out[0]) && !min_delay |-> on_reg > DELAY_COUNT)
      else $error("first enable before delay");
   AST_NEXT_GOOD: assert property (supply_enable_out > $past(supply_enable_out)
      |-> $past(hysteresis_enable, 2) == $past(supply_enable_out))
      else $error("enable without prior good");
   AST_DONE_ON: assert property (rise_done |-> supply_enable_out == 4'hF)
      else $error("done before all on");
   AST_DONE_OFF: assert property ($fell(done_n_oe) |-> supply_enable_out == 4'h0)
      else $error("done released with enables on");
   AST_PGT: assert property (stuck_reg <= PGT_COUNT + 8)
      else $error("timeout not taken");
   AST_FAULT_HOLD: assert property (fault_n_oe [*3] |-> supply_enable_out == 4'h0)
      else $error("enable during fault");
   AST_EXT: assert property (ext_pull |-> supply_enable_out == 4'h0)
      else $error("outside fault ignored");
   AST_INT: assert property ($rose(internal_fault) |-> ##[0:2] fault_n_oe)
      else $error("internal fault not driven");
   AST_OD: assert property (fault_n_out == 1'b0 && done_n_out == 1'b0)
      else $error("open drain data high");
endmodule : pwr_seq_asserts
`default_nettype wire

// ---- testbench/supply_model.sv ----
/* supply_model: four supplies whose good level follows enable after a lag.
 assumes: slow and dead set by tb. */
`default_nettype none
module supply_model (
   input  wire logic       ref_clk,
   input  wire logic [3:0] en,
   input  wire logic       slow,
   input  wire logic [3:0] dead,
   output logic      [3:0] good
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [6:0] lag [4] = '{default: 7'h00};
   initial good = 4'h0;
   // dead channel never rises, or sags from on
   always @(posedge ref_clk) begin
      for (int i = 0; i < 4; i++) begin
         if ((en[i] & ~dead[i]) == good[i]) begin
            lag[i] <= 7'h00;
         end else if (lag[i] == (slow ? 7'h64 : 7'h02)) begin
            good[i] <= ~good[i];
            lag[i] <= 7'h00;
         end else begin
            lag[i] <= lag[i] + 7'h01;
         end
      end
   end
endmodule : supply_model
`default_nettype wire

// ---- testbench/tb.sv ----
/* tb: directed scenarios for the sequencer.
 assumes: supply_model as the supplies; tb is the controller. */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 0, rstn = 0, on_cmd = 0, ext = 0, pgt_enable = 1, min_delay = 0, slow = 0;
   logic [3:0] dead = 4'h0, good, en, hys;
   logic done_n_out, done_n_oe, fault_n_out, fault_n_oe, internal_fault, fault_n_in;
   int err_total = 0, tests_run = 0;
   // own pull left out so clearing sees only outside parties
   assign fault_n_in = !ext;
   four_channel_power_sequencer #(.DELAY_COUNT(24'h000008), .PGT_COUNT(24'h000040)) u_dut (
      .ref_clk(ref_clk), .rstn(rstn), .on_cmd(on_cmd), .supply_good_in(good), .fault_n_in(fault_n_in),
      .pgt_enable(pgt_enable), .min_delay(min_delay), .supply_enable_out(en), .hysteresis_enable(hys),
      .done_n_out(done_n_out), .done_n_oe(done_n_oe), .fault_n_out(fault_n_out),
      .fault_n_oe(fault_n_oe), .internal_fault(internal_fault));
   supply_model u_sup (.ref_clk(ref_clk), .en(en), .slow(slow), .dead(dead), .good(good));
   initial forever #12.5 ref_clk = ~ref_clk;
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask : tick
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("BAD %s exp %h got %h", name, exp, got);
         err_total++;
      end
   endtask : chk
   task automatic wt(input int sel, input logic val, input int lim, output int n);
      n = 0;
      while ((sel == 0 ? done_n_oe : sel == 1 ? fault_n_oe : en[0]) !== val && n < lim) begin
         tick(1);
         n++;
      end
      chk("wait", 8'(val), 8'(sel == 0 ? done_n_oe : sel == 1 ? fault_n_oe : en[0]));
   endtask : wt
   task automatic power_on(output int n);
      on_cmd = 1'b1;
      wt(0, 1'b1, 2000, n);
      chk("en", 8'h0F, 8'(en));
      chk("hys", 8'h0F, 8'(hys));
      chk("fault", 8'h00, 8'(fault_n_oe));
   endtask : power_on
   task automatic power_off();
      int n;
      on_cmd = 1'b0;
      tick(12);
      chk("done", 8'h01, 8'(done_n_oe));
      chk("en", 8'h07, 8'(en));
      wt(0, 1'b0, 2000, n);
      chk("en", 8'h00, 8'(en));
      chk("fault", 8'h00, 8'(fault_n_oe));
   endtask : power_off
   task automatic fault_seen(input logic intl);
      int n;
      wt(1, 1'b1, 200, n);
      chk("en", 8'h00, 8'(en));
      chk("int", 8'(intl), 8'(internal_fault));
   endtask : fault_seen
   task automatic clear();
      int n;
      on_cmd = 1'b0;
      ext = 1'b0;
      dead = 4'h0;
      slow = 1'b0;
      wt(1, 1'b0, 400, n);
   endtask : clear
   task automatic end_of_test();
      if (err_total == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test
   initial begin
      tick(40000);
      err_total++;
      end_of_test();
   end
   initial begin
      int n0, n1;
      tick(16);
      rstn = 1'b1;
      tick(6);
      power_on(n0);
      slow = 1'b1;
      power_off();
      slow = 1'b0;
      {min_delay, pgt_enable} = 2'b10;
      power_on(n1);
      chk("short", 8'h01, 8'(n0 - n1 >= 24));
      power_off();
      {min_delay, pgt_enable, slow} = 3'b001;
      power_on(n1);
      power_off();
      {pgt_enable, slow, on_cmd} = 3'b111;
      fault_seen(1'b1);
      clear();
      on_cmd = 1'b1;
      wt(2, 1'b1, 200, n1);
      on_cmd = 1'b0;
      fault_seen(1'b1);
      clear();
      power_on(n1);
      dead = 4'h2;
      fault_seen(1'b1);
      clear();
      power_on(n1);
      ext = 1'b1;
      tick(8);
      chk("en", 8'h00, 8'(en));
      fault_seen(1'b0);
      on_cmd = 1'b0;
      tick(150);
      chk("held", 8'h01, 8'(fault_n_oe));
      clear();
      end_of_test();
   end
endmodule : tb
bind four_channel_power_sequencer pwr_seq_asserts #(.DELAY_COUNT(DELAY_COUNT), .PGT_COUNT(PGT_COUNT)) u_chk (
   .ref_clk(ref_clk), .rstn(rstn), .on_cmd(on_cmd), .pgt_enable(pgt_enable), .min_delay(min_delay),
   .fault_n_in(fault_n_in), .supply_enable_out(supply_enable_out), .hysteresis_enable(hysteresis_enable),
   .done_n_out(done_n_out), .done_n_oe(done_n_oe), .fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe),
   .internal_fault(internal_fault));
`default_nettype wire
